// ### opd_pkg.sv
`default_nettype none
package opd_pkg;

  // ==========================================================
  // Register map (byte addresses, first byte of each group)
  localparam logic [7:0] OPD_ADDR_FOURTH_DIV = 8'h89;
  localparam logic [7:0] OPD_ADDR_RATIO_A    = 8'h8C;
  localparam logic [7:0] OPD_ADDR_RATIO_B    = 8'h8F;
  localparam int         OPD_NUM_REGS        = 3;
  localparam int         OPD_REG_BYTES       = 3;
  localparam logic [1:0] OPD_LAST_BYTE       = 2'h2;

  // Register indices
  localparam int OPD_IDX_FOURTH = 0;
  localparam int OPD_IDX_A      = 1;
  localparam int OPD_IDX_B      = 2;

  // Reset values
  localparam logic [23:0] OPD_RST_FOURTH_DIV = 24'h000040;
  localparam logic [23:0] OPD_RST_RATIO_A    = 24'h000002;
  localparam logic [23:0] OPD_RST_RATIO_B    = 24'h000002;

  // ==========================================================
  // Field positions and codes
  localparam logic [3:0]  OPD_MODE_FRAME   = 4'hF;
  localparam logic [1:0]  OPD_SEL_RESERVED = 2'h3;
  localparam logic [23:0] OPD_PLAIN_MASK   = 24'h7FFFFF;
  localparam logic [23:0] OPD_MIN_RATIO    = 24'h000002;
  localparam logic [7:0]  OPD_RD_UNMAPPED  = 8'h00;

  // Fourth divider register viewed as frame-pulse fields
  typedef struct packed {
    logic [3:0]  mode;
    logic        gciType;
    logic        invert;
    logic [1:0]  relSel;
    logic [15:0] period;
  } opd_frame_cfg_type;

  // Byte-wide configuration write port
  typedef struct packed {
    logic       wrEn;
    logic [7:0] addr;
    logic [7:0] data;
  } opd_cfg_wr_type;

endpackage
`default_nettype wire

// ### opd_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
module opd_clk_div
  import opd_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Control
  input  wire logic        enable,
  input  wire logic [23:0] ratio,
  // Divided clock
  output var  logic        clkOut_r
);

  logic [23:0] cnt_r;
  logic [23:0] cnt_nxt;
  logic [23:0] highLen;
  logic        runOk;

  // High phase takes the larger half on odd ratios
  assign highLen = (ratio >> 1) + {23'h000000, ratio[0]};
  assign runOk   = enable && (ratio >= OPD_MIN_RATIO);

  always_comb
  begin
    if (cnt_r >= ratio - 24'h000001)
      cnt_nxt = 24'h000000;
    else
      cnt_nxt = cnt_r + 24'h000001;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst || !runOk)
    begin
      cnt_r    <= 24'h000000;
      clkOut_r <= 1'b0;
    end
    else
    begin
      cnt_r    <= cnt_nxt;
      clkOut_r <= (cnt_nxt < highLen);
    end
  end

endmodule
`default_nettype wire

// ### opd_post_divider.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Mode field all ones turns the fourth synth-0 output into a frame pulse.
// - Otherwise a clock divided by the full 24-bit register value, 50% duty on even values.
// - Two-bit select picks related clock: first, second, third divider; 11 reserved.
// - Frame pulse lasts exactly one related-clock period.
// - Polarity bit clear gives normal pulse, set gives inverted pulse.
// - Type bit clear: boundary mid-pulse; set: boundary at pulse edge.
// - First synth-1 divider divides by its unsigned 23-bit value.
// - Second synth-1 divider divides by its own unsigned 23-bit value.
// - Low sixteen bits count related-clock periods between frame pulses.
module opd_post_divider
  import opd_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Configuration register port
  input  wire logic        regWrEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  output var  logic [7:0]  regRdData_r,
  // Related clocks of synthesizer 0 dividers A, B, C
  input  wire logic [2:0]  relClkIn,
  // Output clocks
  output var  logic        fourthOut_r,
  output var  logic        ratioAOut_r,
  output var  logic        ratioBOut_r
);

  // ==========================================================
  // Register file
  localparam logic [7:0] BASE_ADDR [OPD_NUM_REGS] =
    '{OPD_ADDR_FOURTH_DIV, OPD_ADDR_RATIO_A, OPD_ADDR_RATIO_B};
  localparam logic [23:0] RST_VAL [OPD_NUM_REGS] =
    '{OPD_RST_FOURTH_DIV, OPD_RST_RATIO_A, OPD_RST_RATIO_B};

  opd_cfg_wr_type    cfgWr;
  logic [23:0]       cfgReg_r   [OPD_NUM_REGS];
  logic [15:0]       stage_r    [OPD_NUM_REGS];
  logic [OPD_NUM_REGS-1:0] hit;
  logic [1:0]        byteSel    [OPD_NUM_REGS];
  logic [7:0]        rdByte     [OPD_NUM_REGS];
  logic [7:0]        regRdData_nxt;

  assign cfgWr = '{wrEn: regWrEn, addr: regAddr, data: regWrData};

  genvar gi;
  generate
    for (gi = 0; gi < OPD_NUM_REGS; gi = gi + 1)
    begin : g_reg
      logic [7:0] delta;
      assign delta = cfgWr.addr - BASE_ADDR[gi];
      assign hit[gi] = (delta < 8'(OPD_REG_BYTES));
      assign byteSel[gi] = delta[1:0];

      // Lowest address holds the top byte
      always_comb
      begin
        case (byteSel[gi])
          2'h0:    rdByte[gi] = cfgReg_r[gi][23:16];
          2'h1:    rdByte[gi] = cfgReg_r[gi][15:8];
          2'h2:    rdByte[gi] = cfgReg_r[gi][7:0];
          default: rdByte[gi] = OPD_RD_UNMAPPED;
        endcase
      end

      // Upper bytes wait in staging until the last byte lands
      always_ff @(posedge clock)
      begin
        if (sys_rst)
        begin
          stage_r[gi]  <= RST_VAL[gi][23:8];
          cfgReg_r[gi] <= RST_VAL[gi];
        end
        else if (cfgWr.wrEn && hit[gi])
        begin
          case (byteSel[gi])
            2'h0:    stage_r[gi][15:8] <= cfgWr.data;
            2'h1:    stage_r[gi][7:0]  <= cfgWr.data;
            default: cfgReg_r[gi] <= {stage_r[gi], cfgWr.data};
          endcase
        end
      end
    end
  endgenerate

  always_comb
  begin
    regRdData_nxt = OPD_RD_UNMAPPED;
    for (int i = 0; i < OPD_NUM_REGS; i++)
    begin
      if (hit[i])
        regRdData_nxt = rdByte[i];
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      regRdData_r <= OPD_RD_UNMAPPED;
    else
      regRdData_r <= regRdData_nxt;
  end

  // ==========================================================
  // Plain dividers
  opd_frame_cfg_type fpCfg;
  logic              fpMode;
  logic              divClk [OPD_NUM_REGS];
  logic [23:0]       divRatio [OPD_NUM_REGS];
  logic              divEn [OPD_NUM_REGS];

  assign fpCfg  = opd_frame_cfg_type'(cfgReg_r[OPD_IDX_FOURTH]);
  assign fpMode = (fpCfg.mode == OPD_MODE_FRAME);

  assign divRatio[OPD_IDX_FOURTH] = cfgReg_r[OPD_IDX_FOURTH];
  assign divRatio[OPD_IDX_A] = cfgReg_r[OPD_IDX_A] & OPD_PLAIN_MASK;
  assign divRatio[OPD_IDX_B] = cfgReg_r[OPD_IDX_B] & OPD_PLAIN_MASK;
  assign divEn[OPD_IDX_FOURTH] = !fpMode;
  assign divEn[OPD_IDX_A]      = 1'b1;
  assign divEn[OPD_IDX_B]      = 1'b1;

  generate
    for (gi = 0; gi < OPD_NUM_REGS; gi = gi + 1)
    begin : g_div
      opd_clk_div u_div (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .enable   (divEn[gi]),
        .ratio    (divRatio[gi]),
        .clkOut_r (divClk[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Frame pulse generator
  logic        relPrev_r;
  logic        relNow;
  logic        relRise;
  logic        relFall;
  logic [15:0] periodCnt_r;
  logic        lastPeriod;
  logic        relSelOk;
  logic        pulseEdge;
  logic        pulse_r;

  always_comb
  begin
    case (fpCfg.relSel)
      2'h0:    relNow = relClkIn[0];
      2'h1:    relNow = relClkIn[1];
      2'h2:    relNow = relClkIn[2];
      default: relNow = 1'b0;
    endcase
  end

  assign relRise = relNow && !relPrev_r;
  assign relFall = !relNow && relPrev_r;

  // Reserved select parks the pulse at its idle level
  assign relSelOk  = (fpCfg.relSel != OPD_SEL_RESERVED);
  // Type bit picks which related edge frames the pulse
  assign pulseEdge = fpCfg.gciType ? relRise : relFall;
  // Zero period behaves as one
  assign lastPeriod = ({1'b0, periodCnt_r} + 17'h00001) >=
                      {1'b0, fpCfg.period};

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      relPrev_r <= 1'b0;
    else
      relPrev_r <= relNow;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst || !fpMode)
      periodCnt_r <= 16'h0000;
    else if (relRise)
      periodCnt_r <= lastPeriod ? 16'h0000 : periodCnt_r + 16'h0001;
  end

  // Pulse spans one related period, edge or straddling aligned
  always_ff @(posedge clock)
  begin
    if (sys_rst || !fpMode || !relSelOk)
      pulse_r <= 1'b0;
    else if (pulseEdge)
      pulse_r <= lastPeriod;
  end

  // ==========================================================
  // Output stage
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      fourthOut_r <= 1'b0;
      ratioAOut_r <= 1'b0;
      ratioBOut_r <= 1'b0;
    end
    else
    begin
      // Frame mode bypasses the fourth plain divider
      fourthOut_r <= fpMode ? (pulse_r ^ fpCfg.invert)
                            : divClk[OPD_IDX_FOURTH];
      ratioAOut_r <= divClk[OPD_IDX_A];
      ratioBOut_r <= divClk[OPD_IDX_B];
    end
  end

endmodule
`default_nettype wire

// ### opd_post_divider_props.sv
`timescale 1ns/1ps
`default_nettype none
module opd_post_divider_props
  import opd_pkg::*;
(
  // Clock and reset
  input wire logic       clock,
  input wire logic       sys_rst,
  // Register port
  input wire logic       regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData_r,
  // Clocks
  input wire logic [2:0] relClkIn,
  input wire logic       fourthOut_r,
  input wire logic       ratioAOut_r,
  input wire logic       ratioBOut_r
);
  // ==========================================================
  // Shadow of the fourth divider register
  logic [15:0] stage_r;
  logic [23:0] shadow_r;
  logic [3:0]  settle_r;
  wire logic   frame;
  wire logic   commit;
  assign frame = shadow_r[23:20] == OPD_MODE_FRAME;
  assign commit = regWrEn && regAddr == 8'h8B;
  always_ff @(posedge clock)
  begin
    if (sys_rst) stage_r <= OPD_RST_FOURTH_DIV[23:8];
    else
    begin
      if (regWrEn && regAddr == 8'h89) stage_r[15:8] <= regWrData;
      if (regWrEn && regAddr == 8'h8A) stage_r[7:0] <= regWrData;
    end
  end
  always_ff @(posedge clock)
  begin
    if (sys_rst) shadow_r <= OPD_RST_FOURTH_DIV;
    else if (commit) shadow_r <= {stage_r, regWrData};
  end
  always_ff @(posedge clock)
  begin
    if (sys_rst || commit) settle_r <= 4'h0;
    else if (settle_r != 4'hF) settle_r <= settle_r + 4'h1;
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  reset_clear_a: assert property ($fell(sys_rst) |-> !fourthOut_r &&
    !ratioAOut_r && !ratioBOut_r && regRdData_r == 8'h00)
    else $error("outputs not clear after reset");
  unmapped_read_a: assert property ((regAddr < 8'h89 || regAddr > 8'h91)
    |=> regRdData_r == OPD_RD_UNMAPPED) else $error("unmapped read not zero");
  commit_read_a: assert property ((regWrEn && regAddr == 8'h8C) ##2
    (regWrEn && regAddr == 8'h8E) ##1 (!regWrEn && regAddr == 8'h8C)
    |=> regRdData_r == $past(regWrData, 4)) else $error("commit lost");
  staged_hidden_a: assert property ((!regWrEn && regAddr == 8'h8C) ##1
    (regWrEn && regAddr == 8'h8C) ##1 (!regWrEn && regAddr == 8'h8C)
    |=> $stable(regRdData_r)) else $error("staged byte visible");
  read_stable_a: assert property (!regWrEn ##1
    (!regWrEn && $stable(regAddr)) |=> $stable(regRdData_r))
    else $error("read changed without write");
  shadow_read_a: assert property (commit ##1
    (!regWrEn && regAddr == 8'h89) |=> regRdData_r == shadow_r[23:16])
    else $error("fourth divider readback wrong");
  reserved_idle_a: assert property (frame && settle_r > 4'h8 &&
    shadow_r[17:16] == OPD_SEL_RESERVED |-> fourthOut_r == shadow_r[18])
    else $error("reserved select not idle");
  low_hold_a: assert property (!frame && shadow_r < 24'h000002 &&
    settle_r > 4'h8 |-> !fourthOut_r) else $error("ratio below two not low");
endmodule
bind opd_post_divider opd_post_divider_props props_u (.clock(clock),
  .sys_rst(sys_rst), .regWrEn(regWrEn), .regAddr(regAddr),
  .regWrData(regWrData), .regRdData_r(regRdData_r), .relClkIn(relClkIn),
  .fourthOut_r(fourthOut_r), .ratioAOut_r(ratioAOut_r),
  .ratioBOut_r(ratioBOut_r));
`default_nettype wire

// ### opd_rel_clk_model.sv
`timescale 1ns/1ps
`default_nettype none
module opd_rel_clk_model
  import opd_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  output var  logic [2:0] relClkIn
);
  logic [4:0] cnt_r;
  always_ff @(posedge clock)
  begin
    if (sys_rst || cnt_r == 5'h17) cnt_r <= 5'h00;
    else cnt_r <= cnt_r + 5'h01;
  end
  // Three distinct related clocks of 4, 6 and 8 cycles
  always_ff @(posedge clock)
  begin
    relClkIn <= {cnt_r % 5'h08 < 5'h04, cnt_r % 5'h06 < 5'h03,
      cnt_r % 5'h04 < 5'h02};
  end
endmodule
`default_nettype wire

// ### output_post_divider_frame_pulse_tb.sv
`timescale 1ns/1ps
`default_nettype none
module output_post_divider_frame_pulse_tb;
  import opd_pkg::*;
  logic       clock;
  logic       sys_rst;
  logic       regWrEn;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  wire logic [7:0] regRdData_r;
  wire logic [2:0] relClkIn;
  wire logic [2:0] outs;
  int         num_errors = 0;
  int         checks = 0;
  opd_post_divider dut_u (.clock(clock), .sys_rst(sys_rst),
    .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData_r(regRdData_r), .relClkIn(relClkIn),
    .fourthOut_r(outs[2]), .ratioAOut_r(outs[0]), .ratioBOut_r(outs[1]));
  opd_rel_clk_model rel_u (.clock(clock), .sys_rst(sys_rst),
    .relClkIn(relClkIn));
  // ==========================================================
  // Tasks
  task automatic give_verdict();
    $display("Errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic wb(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
  endtask
  task automatic rb(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    regWrEn <= 1'b0;
    regAddr <= a;
    step();
    chk({16'h0000, regRdData_r}, {16'h0000, e});
  endtask
  task automatic wr3(input logic [7:0] a, input logic [23:0] v);
    wb(a, v[23:16]);
    wb(a + 8'h01, v[15:8]);
    wb(a + 8'h02, v[7:0]);
  endtask
  task automatic rd3(input logic [7:0] a, input logic [23:0] v);
    rb(a, v[23:16]);
    rb(a + 8'h01, v[15:8]);
    rb(a + 8'h02, v[7:0]);
  endtask
  // High and low run lengths of one output
  task automatic meas(input int w, input int h, input int l);
    int hc;
    int lc;
    hc = 0;
    lc = 0;
    // Align to the first high sample after a rising edge
    while (outs[w] === 1'b1 && hc < 99)
    begin
      step();
      hc++;
    end
    while (outs[w] !== 1'b1 && lc < 99)
    begin
      step();
      lc++;
    end
    hc = 0;
    lc = 0;
    while (outs[w] === 1'b1 && hc < 99)
    begin
      step();
      hc++;
    end
    while (outs[w] === 1'b0 && lc < 99)
    begin
      step();
      lc++;
    end
    chk(24'(hc), 24'(h));
    chk(24'(lc), 24'(l));
  endtask
  task automatic run(input logic [7:0] a, input logic [23:0] v,
    input int w, input int h, input int l);
    wr3(a, v);
    rd3(a, v);
    repeat (60) step();
    meas(w, h, l);
  endtask
  task automatic idle(input logic [23:0] v, input logic lvl);
    wr3(8'h89, v);
    rb(8'h8B, v[7:0]);
    repeat (20) step();
    chk({23'h0, outs[2]}, {23'h0, lvl});
  endtask
  // ==========================================================
  // Clock, watchdog and tests
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    #100000;
    num_errors++;
    give_verdict();
  end
  initial
  begin
    sys_rst = 1'b1;
    regWrEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    rd3(8'h89, OPD_RST_FOURTH_DIV);
    rd3(8'h8C, OPD_RST_RATIO_A);
    rd3(8'h8F, OPD_RST_RATIO_B);
    wb(8'h92, 8'hFF);
    rb(8'h92, 8'h00);
    rb(8'h88, 8'h00);
    meas(0, 1, 1);
    run(8'h8C, 24'h000005, 0, 3, 2);
    rb(8'h8C, 8'h00);
    wb(8'h8C, 8'h12);
    rb(8'h8C, 8'h00);
    run(8'h8F, 24'h000004, 1, 2, 2);
    run(8'h89, 24'h000007, 2, 4, 3);
    run(8'h89, 24'hF80003, 2, 4, 8);
    run(8'h89, 24'hF00003, 2, 4, 8);
    run(8'h89, 24'hF40003, 2, 8, 4);
    run(8'h89, 24'hF90002, 2, 6, 6);
    run(8'h89, 24'hFA0003, 2, 8, 16);
    idle(24'hFB0003, 1'b0);
    idle(24'hFF0003, 1'b1);
    idle(24'h000001, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
